//--- hdl/panel_mode_pkg.sv
// Constants for the operator-panel mode block.
// Assumes a 25 MHz system clock; all names used as panel_mode_pkg::name.
package panel_mode_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ            = 25_000_000;
   localparam int CHANGE_WINDOW_S   = 10;
   localparam int CHANGE_WINDOW_CYC = CHANGE_WINDOW_S * CLK_HZ;
   // ==========================================================
   // Register map (byte addresses, one word each)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_REMOTE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // Control register fields
   localparam int CTRL_GND_BLK  = 0;
   localparam int CTRL_NON_RECL = 1;
   localparam int CTRL_CSP_BLK  = 2;
   localparam int CTRL_FAST_DIS = 3;
   localparam int CTRL_PROF_LSB = 4;
   localparam int CTRL_SUP_CLR  = 6;
   localparam int CTRL_SET_EN   = 7;
   // Remote hot line tag fields (port 2, port 3)
   localparam int REM_TAG_P2 = 0;
   localparam int REM_TAG_P3 = 1;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // ==========================================================
   // Change window state
   typedef enum logic [1:0] {
      CW_IDLE = 2'b00,
      CW_OPEN = 2'b01
   } cw_state_t;
   // Panel operation key index
   localparam int KEY_GND  = 0;
   localparam int KEY_NREC = 1;
   localparam int KEY_SUP  = 2;
   localparam int KEY_CSP  = 3;
   localparam int KEY_BAT  = 4;
   localparam int KEY_FAST = 5;
   localparam int KEY_ALT1 = 6;
   localparam int KEY_ALT2 = 7;
   localparam int KEY_ALT3 = 8;
   localparam int NUM_KEYS = 9;
   // Curve selection codes
   localparam logic [1:0] CURVE_NORMAL = 2'h0;
   localparam logic [1:0] CURVE_CSP    = 2'h1;
   localparam logic [1:0] CURVE_FAST   = 2'h2;
   localparam logic [1:0] CURVE_HOT    = 2'h3;
endpackage

//--- hdl/panel_operation_mode_control.sv
// Operator panel mode logic: change window, function states, profiles, hot line tag.
// Assumes key and pin inputs are debounced but asynchronous; bus is on mclk_i.
// Contract
// [R1] Change key opens 10 second window
// [R2] Window expiry leaves functions unchanged
// [R3] Indicators show state from any source
// [R4] Power-save keeps operation indicators dark
// [R5] Ground key in window sets blocking
// [R6] Non-reclosing suppresses reclose, keeps curve
// [R7] Supervisory block rejects supervisory, software commands
// [R8] Local trip/close always operate; the close button is blocked while the hot tag is active
// [R9] Supervisory block set only from keypad
// [R10] Unblocked cold pickup substitutes first operation
// [R11] Battery test lights until test done
// [R12] Fast trips disabled uses dedicated curve
// [R13] Normal profile when no alternate lit
// [R14] Alternate selected by change then key
// [R15] Hot tag blocks closing, never trips
// [R16] Hot tag: one trip, hot curve
// [R17] Hot tag overrides pickup, nonreclose, fast
// [R18] Hot tag is OR of four sources
// [R19] Each tag cleared only by its source
// [R20] Panel serial connection disables port-2 accessory
// [R21] At most one alternate profile lit
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
module panel_operation_mode_control #(
   parameter int WINDOW_CYC = panel_mode_pkg::CHANGE_WINDOW_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   // Register bus
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Panel inputs (asynchronous)
   input  wire logic        change_key_i,
   input  wire logic [8:0]  op_key_i,
   input  wire logic        tag_switch_i,
   input  wire logic        dif_tag_i,
   input  wire logic        power_save_i,
   input  wire logic        panel_serial_conn_i,
   input  wire logic        trip_button_i,
   input  wire logic        close_button_i,
   // Protection and battery side (same clock)
   input  wire logic        battery_done_i,
   input  wire logic        first_operation_i,
   input  wire logic        reclose_req_i,
   input  wire logic        close_req_i,
   input  wire logic        trip_req_i,
   input  wire logic        supv_cmd_i,
   input  wire logic        sw_cmd_i,
   // Outputs
   output logic [8:0]       op_led_o,
   output logic             tag_led_o,
   output logic             change_mode_o,
   output logic             battery_start_o,
   output logic [1:0]       profile_o,
   output logic [1:0]       curve_sel_o,
   output logic             single_trip_lockout_o,
   output logic             reclose_o,
   output logic             close_o,
   output logic             trip_o,
   output logic             supv_accept_o,
   output logic             sw_accept_o,
   output logic             gnd_trip_block_o,
   output logic             p2_accessory_en_o
);
   // ==========================================================
   // Input synchronisers
   localparam int NSYNC = 16;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] sync_prev;
   logic [NSYNC-1:0] raw_in;
   assign raw_in = {close_button_i, trip_button_i, panel_serial_conn_i, power_save_i,
                    dif_tag_i, tag_switch_i, change_key_i, op_key_i};

   // Two flops per asynchronous input; previous copy feeds edge detection
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sync1     <= '0;
         sync2     <= '0;
         sync_prev <= '0;
      end else begin
         sync1     <= raw_in;
         sync2     <= sync1;
         sync_prev <= sync2;
      end
   end

   logic [8:0] key_press;
   logic       change_press;
   logic       tag_sw;
   logic       dif_tag;
   logic       pwr_save;
   logic       serial_conn;
   logic       trip_btn;
   logic       close_btn;
   assign key_press    = sync2[8:0] & ~sync_prev[8:0];
   assign change_press = sync2[9] & ~sync_prev[9];
   assign tag_sw       = sync2[10];
   assign dif_tag      = sync2[11];
   assign pwr_save     = sync2[12];
   assign serial_conn  = sync2[13];
   assign trip_btn     = sync2[14];
   assign close_btn    = sync2[15];

   // ==========================================================
   // Change window
   panel_mode_pkg::cw_state_t cw_state;
   logic [31:0]               cw_count;
   logic                      key_in_window;
   assign key_in_window = (cw_state == panel_mode_pkg::CW_OPEN) && (|key_press);

   // Window opens on change key, closes on a selection or on expiry
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cw_state <= panel_mode_pkg::CW_IDLE;
         cw_count <= '0;
      end else begin
         case (cw_state)
            panel_mode_pkg::CW_IDLE: begin
               if (change_press) begin
                  cw_state <= panel_mode_pkg::CW_OPEN; // [R1]
                  cw_count <= 32'(WINDOW_CYC - 1);
               end
            end
            panel_mode_pkg::CW_OPEN: begin
               if (key_in_window) begin
                  cw_state <= panel_mode_pkg::CW_IDLE;
               end else if (cw_count == '0) begin
                  cw_state <= panel_mode_pkg::CW_IDLE; // [R2]
               end else begin
                  cw_count <= cw_count - 32'd1;
               end
            end
            default: begin
               cw_state <= panel_mode_pkg::CW_IDLE;
            end
         endcase
      end
   end

   // Keys outside the window are ignored, so expiry changes nothing
   logic [8:0] key_act;
   assign key_act = key_in_window ? key_press : 9'h000; // [R2]

   // ==========================================================
   // Software register access
   logic       sup_blk;
   logic       sw_wr_ctrl;
   logic       sw_wr_rem;
   assign sw_wr_ctrl = wr_i && (addr_i == panel_mode_pkg::ADDR_CTRL) && !sup_blk; // [R7]
   assign sw_wr_rem  = wr_i && (addr_i == panel_mode_pkg::ADDR_REMOTE);

   // ==========================================================
   // Function states, panel or remote
   logic gnd_blk;
   logic non_recl;
   logic csp_blk;
   logic fast_dis;

   // Toggle from keypad, or write from remote; both update the same state
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         gnd_blk  <= panel_mode_pkg::CTRL_RESET[panel_mode_pkg::CTRL_GND_BLK];
         non_recl <= panel_mode_pkg::CTRL_RESET[panel_mode_pkg::CTRL_NON_RECL];
         csp_blk  <= panel_mode_pkg::CTRL_RESET[panel_mode_pkg::CTRL_CSP_BLK];
         fast_dis <= panel_mode_pkg::CTRL_RESET[panel_mode_pkg::CTRL_FAST_DIS];
      end else if (|key_act) begin
         if (key_act[panel_mode_pkg::KEY_GND]) begin
            gnd_blk <= ~gnd_blk; // [R5]
         end
         if (key_act[panel_mode_pkg::KEY_NREC]) begin
            non_recl <= ~non_recl;
         end
         if (key_act[panel_mode_pkg::KEY_CSP]) begin
            csp_blk <= ~csp_blk;
         end
         if (key_act[panel_mode_pkg::KEY_FAST]) begin
            fast_dis <= ~fast_dis;
         end
      end else if (sw_wr_ctrl && wdata_i[panel_mode_pkg::CTRL_SET_EN]) begin
         gnd_blk  <= wdata_i[panel_mode_pkg::CTRL_GND_BLK]; // [R3]
         non_recl <= wdata_i[panel_mode_pkg::CTRL_NON_RECL];
         csp_blk  <= wdata_i[panel_mode_pkg::CTRL_CSP_BLK];
         fast_dis <= wdata_i[panel_mode_pkg::CTRL_FAST_DIS];
      end
   end

   // Supervisory blocking: keypad only; software writes can neither set nor clear it
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sup_blk <= 1'b0;
      end else if (key_act[panel_mode_pkg::KEY_SUP]) begin
         sup_blk <= ~sup_blk; // [R9]
      end
   end

   // ==========================================================
   // Profiles: 0 normal, 1..3 alternates; binary coded, so at most one alternate lamp by construction
   logic [1:0] profile;
   logic [1:0] key_prof;
   logic [1:0] wr_prof;
   assign key_prof = key_act[panel_mode_pkg::KEY_ALT3] ? 2'd3 :
                     key_act[panel_mode_pkg::KEY_ALT2] ? 2'd2 : 2'd1;
   assign wr_prof  = wdata_i[panel_mode_pkg::CTRL_PROF_LSB +: 2];

   // Pressing the active alternate drops back to normal
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         profile <= 2'd0;
      end else if (|key_act[8:6]) begin
         profile <= (profile == key_prof) ? 2'd0 : key_prof; // [R14] [R21]
      end else if (sw_wr_ctrl && wdata_i[panel_mode_pkg::CTRL_SET_EN]) begin
         profile <= wr_prof; // [R14]
      end
   end

   // ==========================================================
   // Battery test indicator
   logic bat_busy;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bat_busy <= 1'b0;
      end else if (key_act[panel_mode_pkg::KEY_BAT] && !bat_busy) begin
         bat_busy <= 1'b1; // [R11]
      end else if (battery_done_i) begin
         bat_busy <= 1'b0; // [R11]
      end
   end
   assign battery_start_o = key_act[panel_mode_pkg::KEY_BAT] && !bat_busy;

   // ==========================================================
   // Hot line tag: one request per source, cleared only by that source
   logic tag_p2;
   logic tag_p3;
   logic hot_tag;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         tag_p2 <= 1'b0;
         tag_p3 <= 1'b0;
      end else if (sw_wr_rem) begin
         tag_p2 <= wdata_i[panel_mode_pkg::REM_TAG_P2]; // [R19]
         tag_p3 <= wdata_i[panel_mode_pkg::REM_TAG_P3]; // [R19]
      end
   end
   // Panel and discrete tags follow their own inputs only
   assign hot_tag = tag_sw | tag_p2 | tag_p3 | dif_tag; // [R18] [R19]

   // ==========================================================
   // Protection steering
   always_comb begin
      if (hot_tag) begin
         curve_sel_o = panel_mode_pkg::CURVE_HOT; // [R16] [R17]
      end else if (fast_dis) begin
         curve_sel_o = panel_mode_pkg::CURVE_FAST; // [R12]
      end else if (!csp_blk && first_operation_i) begin
         curve_sel_o = panel_mode_pkg::CURVE_CSP; // [R10]
      end else begin
         curve_sel_o = panel_mode_pkg::CURVE_NORMAL; // [R6]
      end
   end
   assign single_trip_lockout_o = hot_tag; // [R16]
   assign reclose_o     = reclose_req_i && !non_recl && !hot_tag; // [R6] [R15]
   assign close_o       = (close_req_i || close_btn) && !hot_tag; // [R8] [R15]
   assign trip_o        = trip_req_i || trip_btn; // [R8] [R15]
   assign supv_accept_o = supv_cmd_i && !sup_blk; // [R7]
   assign sw_accept_o   = sw_cmd_i && !sup_blk; // [R7]
   assign gnd_trip_block_o  = gnd_blk;
   assign p2_accessory_en_o = !serial_conn; // [R20]
   assign change_mode_o     = (cw_state == panel_mode_pkg::CW_OPEN);
   assign profile_o         = profile; // [R13]

   // ==========================================================
   // Indicators; operation lamps dark in power-save, tag lamp not
   logic [8:0] led_state;
   always_comb begin
      led_state = '0;
      led_state[panel_mode_pkg::KEY_GND]  = gnd_blk;
      led_state[panel_mode_pkg::KEY_NREC] = non_recl;
      led_state[panel_mode_pkg::KEY_SUP]  = sup_blk;
      led_state[panel_mode_pkg::KEY_CSP]  = csp_blk;
      led_state[panel_mode_pkg::KEY_BAT]  = bat_busy;
      led_state[panel_mode_pkg::KEY_FAST] = fast_dis;
      led_state[panel_mode_pkg::KEY_ALT1] = (profile == 2'd1); // [R13]
      led_state[panel_mode_pkg::KEY_ALT2] = (profile == 2'd2);
      led_state[panel_mode_pkg::KEY_ALT3] = (profile == 2'd3);
   end

   // Registered so the lamps never glitch
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         op_led_o  <= '0;
         tag_led_o <= 1'b0;
      end else begin
         op_led_o  <= pwr_save ? 9'h000 : led_state; // [R3] [R4]
         tag_led_o <= hot_tag;
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         if (addr_i == panel_mode_pkg::ADDR_CTRL) begin
            rdata_o <= {24'h000000, 1'b0, sup_blk, profile, fast_dis, csp_blk,
                        non_recl, gnd_blk};
         end else if (addr_i == panel_mode_pkg::ADDR_REMOTE) begin
            rdata_o <= {30'h00000000, tag_p3, tag_p2};
         end else if (addr_i == panel_mode_pkg::ADDR_STATUS) begin
            rdata_o <= {24'h000000, serial_conn, pwr_save, dif_tag, tag_sw,
                        hot_tag, bat_busy, change_mode_o, 1'b0};
         end else begin
            rdata_o <= '0;
         end
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

//--- tb/panel_keypad_model.sv
// Keypad and panel tag switch model standing in front of the panel inputs.
// Assumes callers enter its tasks just after a rising edge of mclk_i.
`timescale 1ns/10ps
module panel_keypad_model (
   input  wire logic       mclk_i,
   output logic            change_key_o,
   output logic      [8:0] op_key_o,
   output logic            tag_switch_o
);
   // ==========
   // Keys released, toggle off
   initial begin
      change_key_o = 1'b0;
      op_key_o     = 9'h000;
      tag_switch_o = 1'b0;
   end
   // Change key, then one key; held long enough to pass the syncs
   task automatic press(input int k);
      change_key_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      change_key_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      if (k < 9) op_key_o[k] <= 1'b1; // Nine lets the window lapse
      repeat (4) @(posedge mclk_i);
      op_key_o <= 9'h000;
      repeat (4) @(posedge mclk_i);
   endtask
   // Panel toggle releases only its own tag request
   task automatic tag(input logic v);
      tag_switch_o <= v;
   endtask
endmodule

//--- tb/panel_mode_checker_assertions.sv
// Port-level checks of the panel mode block, bound into it.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module panel_mode_checker #(
   parameter int WINDOW_CYC = panel_mode_pkg::CHANGE_WINDOW_CYC
) (
   input wire logic       mclk_i,
   input wire logic       rst_b_i,
   input wire logic       tag_switch_i,
   input wire logic       dif_tag_i,
   input wire logic       power_save_i,
   input wire logic       panel_serial_conn_i,
   input wire logic [8:0] op_led_o,
   input wire logic       tag_led_o,
   input wire logic       change_mode_o,
   input wire logic       battery_start_o,
   input wire logic [1:0] profile_o,
   input wire logic [1:0] curve_sel_o,
   input wire logic       single_trip_lockout_o,
   input wire logic       reclose_o,
   input wire logic       close_o,
   input wire logic       p2_accessory_en_o
);
   // ==========
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   localparam logic [1:0] HOT = panel_mode_pkg::CURVE_HOT;
   // Open-window length; a long count would not unroll in a property
   logic [31:0] cw_cnt;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i || !change_mode_o) cw_cnt <= 32'h0;
      else cw_cnt <= cw_cnt + 32'h1;
   end
   // ==========
   win_bound_a: assert property (cw_cnt <= WINDOW_CYC)
      else $error("change window open too long");
   hot_no_close_a: assert property (curve_sel_o == HOT |-> !close_o && !reclose_o)
      else $error("close passed during hot tag");
   hot_one_trip_a: assert property (single_trip_lockout_o == (curve_sel_o == HOT))
      else $error("single trip not tied to hot curve");
   hot_overrides_a: assert property (tag_led_o ##1 tag_led_o |-> $past(curve_sel_o) == HOT)
      else $error("hot tag lost precedence");
   tag_sources_a: assert property ((tag_switch_i || dif_tag_i) [*4] |-> curve_sel_o == HOT)
      else $error("local tag source ignored");
   dark_save_a: assert property (power_save_i [*4] |-> op_led_o == 9'h000)
      else $error("indicator lit in power save");
   acc_off_a: assert property (panel_serial_conn_i [*3] |-> !p2_accessory_en_o)
      else $error("accessory left on with serial connection");
   one_alt_a: assert property ($countones(op_led_o[8:6]) <= 1)
      else $error("two alternate indicators lit");
   normal_prof_a: assert property ($stable(profile_o) && profile_o == 2'h0
      |-> op_led_o[8:6] == 3'h0)
      else $error("alternate lit under normal profile");
   bat_pulse_a: assert property (battery_start_o |=> !battery_start_o)
      else $error("battery start longer than a cycle");
   // Main scenarios reached
   cover property (curve_sel_o == HOT);
   cover property ($fell(change_mode_o));
   cover property (profile_o == 2'h3);
endmodule
bind panel_operation_mode_control panel_mode_checker #(.WINDOW_CYC(WINDOW_CYC))
   panel_mode_checker_inst (.mclk_i, .rst_b_i, .tag_switch_i, .dif_tag_i, .power_save_i,
   .panel_serial_conn_i, .op_led_o, .tag_led_o, .change_mode_o, .battery_start_o, .profile_o,
   .curve_sel_o, .single_trip_lockout_o, .reclose_o, .close_o, .p2_accessory_en_o);

//--- tb/panel_operation_mode_control_tb_top.sv
// Self-checking bench for the operator panel mode block.
// Assumes the keypad model and the checker are compiled before it.
`timescale 1ns/10ps
module panel_operation_mode_control_tb_top;
   // ==========
   // Signals carry the port names so the instance connects by name
   logic        mclk_i, rst_b_i, wr_i, rd_i, change_key_i, tag_switch_i, dif_tag_i;
   logic        power_save_i, panel_serial_conn_i, trip_button_i, close_button_i;
   logic        battery_done_i, first_operation_i, reclose_req_i, close_req_i;
   logic        trip_req_i, supv_cmd_i, sw_cmd_i, tag_led_o, change_mode_o;
   logic        battery_start_o, single_trip_lockout_o, reclose_o, close_o, trip_o;
   logic        supv_accept_o, sw_accept_o, gnd_trip_block_o, p2_accessory_en_o;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [8:0]  op_key_i, op_led_o;
   logic [1:0]  profile_o, curve_sel_o;
   int          n_errors = 0;
   int          checks_done = 0;
   int          n_bat_starts = 0;
   // Start pulse lasts one cycle, so it is counted rather than sampled
   always @(posedge mclk_i) begin
      if (battery_start_o === 1'b1) n_bat_starts++;
   end
   // Short window keeps the run brief
   panel_operation_mode_control #(.WINDOW_CYC(20)) panel_operation_mode_control_inst (
      .mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .change_key_i,
      .op_key_i, .tag_switch_i, .dif_tag_i, .power_save_i, .panel_serial_conn_i,
      .trip_button_i, .close_button_i, .battery_done_i, .first_operation_i, .reclose_req_i,
      .close_req_i, .trip_req_i, .supv_cmd_i, .sw_cmd_i, .op_led_o, .tag_led_o,
      .change_mode_o, .battery_start_o, .profile_o, .curve_sel_o, .single_trip_lockout_o,
      .reclose_o, .close_o, .trip_o, .supv_accept_o, .sw_accept_o, .gnd_trip_block_o,
      .p2_accessory_en_o);
   panel_keypad_model panel_keypad_model_inst (
      .mclk_i, .change_key_o(change_key_i), .op_key_o(op_key_i), .tag_switch_o(tag_switch_i));
   // ==========
   // Shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Idle edge after each write so strobes never meet in one step
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      tick(1);
      wr_i    <= 1'b0;
      tick(1);
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i   <= 1'b1;
      tick(1);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
      tick(1);
   endtask
   task automatic press(input int k);
      panel_keypad_model_inst.press(k);
   endtask
   // ==========
   // Lapsed window changes nothing; ground key inside one does
   task automatic t_window();
      press(9);
      chk(change_mode_o, 1'b1);
      tick(20);
      chk({change_mode_o, op_led_o, gnd_trip_block_o}, 32'h0);
      press(panel_mode_pkg::KEY_GND);
      chk({change_mode_o, op_led_o, gnd_trip_block_o}, 32'h3);
   endtask
   // Alternates replace each other; remote writes light indicators too
   task automatic t_profile();
      for (int k = 6; k < 9; k++) begin
         press(k);
         chk({profile_o, op_led_o[8:6]}, {2'(k - 5), 3'(1 << (k - 6))});
      end
      press(8);
      chk({profile_o, op_led_o[8:6]}, 32'h0);
      // Lamps are registered, so they lag the written profile by one edge
      bus_wr(panel_mode_pkg::ADDR_CTRL, 32'hA1);
      tick(1);
      chk({profile_o, op_led_o[8:6]}, {2'h2, 3'h2});
      bus_wr(panel_mode_pkg::ADDR_CTRL, 32'h81);
      tick(1);
      chk({profile_o, op_led_o[8:6]}, 32'h0);
   endtask
   task automatic t_curve();
      first_operation_i <= 1'b1;
      reclose_req_i     <= 1'b1;
      tick(2);
      chk({curve_sel_o, reclose_o}, {panel_mode_pkg::CURVE_CSP, 1'b1});
      press(panel_mode_pkg::KEY_NREC);
      chk({curve_sel_o, reclose_o}, {panel_mode_pkg::CURVE_CSP, 1'b0});
      press(panel_mode_pkg::KEY_CSP);
      chk(curve_sel_o, panel_mode_pkg::CURVE_NORMAL);
      press(panel_mode_pkg::KEY_FAST);
      chk(curve_sel_o, panel_mode_pkg::CURVE_FAST);
   endtask
   // Sources: panel toggle, discrete pin, port 2 bit, port 3 bit
   task automatic set_src(input int s, input logic v);
      case (s)
         0: panel_keypad_model_inst.tag(v);
         1: dif_tag_i <= v;
         default: bus_wr(panel_mode_pkg::ADDR_REMOTE, {30'h0, v, 1'b0} >> (3 - s));
      endcase
   endtask
   task automatic t_hot();
      close_req_i <= 1'b1;
      trip_req_i  <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         set_src(s, 1'b1);
         tick(5);
         chk({tag_led_o, curve_sel_o, single_trip_lockout_o, close_o, reclose_o, trip_o},
             7'h79);
         set_src(s, 1'b0);
         tick(5);
         chk({tag_led_o, curve_sel_o}, 3'h2);
      end
      set_src(0, 1'b1);
      bus_wr(panel_mode_pkg::ADDR_REMOTE, 32'h3);
      bus_wr(panel_mode_pkg::ADDR_REMOTE, 32'h2);
      set_src(0, 1'b0);
      tick(5);
      chk(tag_led_o, 1'b1);
      bus_wr(panel_mode_pkg::ADDR_REMOTE, 32'h0);
      tick(5);
      chk(tag_led_o, 1'b0);
      close_req_i <= 1'b0;
      trip_req_i  <= 1'b0;
   endtask
   task automatic t_supv();
      logic [31:0] d;
      supv_cmd_i <= 1'b1;
      sw_cmd_i   <= 1'b1;
      tick(1);
      chk({supv_accept_o, sw_accept_o}, 2'h3);
      press(panel_mode_pkg::KEY_SUP);
      chk({supv_accept_o, sw_accept_o}, 2'h0);
      bus_wr(panel_mode_pkg::ADDR_CTRL, 32'h80);
      bus_rd(panel_mode_pkg::ADDR_CTRL, d);
      chk(d & 32'h7F, 32'h4F);
      bus_rd(8'h0C, d);
      chk(d, 32'h0);
      trip_button_i  <= 1'b1;
      close_button_i <= 1'b1;
      tick(4);
      chk({trip_o, close_o}, 2'h3);
   endtask
   // Battery lamp, then dark panel and serial connection
   task automatic t_battery_save();
      press(panel_mode_pkg::KEY_BAT);
      chk(op_led_o, 9'h03F);
      chk(n_bat_starts, 1);
      battery_done_i <= 1'b1;
      tick(1);
      battery_done_i <= 1'b0;
      tick(2);
      chk(op_led_o, 9'h02F);
      power_save_i        <= 1'b1;
      panel_serial_conn_i <= 1'b1;
      tick(5);
      chk({op_led_o, p2_accessory_en_o}, 10'h0);
      power_save_i        <= 1'b0;
      panel_serial_conn_i <= 1'b0;
      tick(5);
      chk({op_led_o, p2_accessory_en_o}, {9'h02F, 1'b1});
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ==========
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // Whole sequence needs under a thousand cycles
   initial begin
      #200_000;
      n_errors++;
      give_verdict();
   end
   initial begin
      {rst_b_i, wr_i, rd_i, addr_i, wdata_i, dif_tag_i, power_save_i} = '0;
      {panel_serial_conn_i, trip_button_i, close_button_i, battery_done_i} = '0;
      {first_operation_i, reclose_req_i, close_req_i, trip_req_i, supv_cmd_i, sw_cmd_i} = '0;
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      tick(4);
      chk({profile_o, curve_sel_o, op_led_o, p2_accessory_en_o, change_mode_o}, 32'h2);
      t_window();
      t_profile();
      t_curve();
      t_hot();
      t_supv();
      t_battery_save();
      give_verdict();
   end
endmodule
